// *** core/slot_lvl_pkg.sv ***
// shared constants and carriers for the slot level interrupt block
package slot_lvl_pkg;
   // slot and word geometry
   localparam int unsigned NUM_SLOTS = 12;
   localparam int unsigned REG_W = 16;
   localparam int unsigned CNT_W = 11;
   localparam int unsigned ADDR_W = 8;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_DATA_FLAGS = 6'h01;
   localparam logic [5:0] IDX_LEVEL0_FLAGS = 6'h02;
   localparam logic [5:0] IDX_LEVEL1_FLAGS = 6'h03;
   localparam logic [5:0] IDX_ACLEAR_EN = 6'h07;
   localparam logic [5:0] IDX_FIFO_THRESH = 6'h08;
   localparam logic [5:0] IDX_MASK_DATA = 6'h10;
   localparam logic [5:0] IDX_MASK_LEVEL0 = 6'h11;
   localparam logic [5:0] IDX_MASK_LEVEL1 = 6'h12;
   // field positions
   localparam int unsigned FIFO_THRESH_BIT = 15;
   localparam int unsigned FIFO_ACLEAR_BIT = 15;
   // values after reset
   localparam logic [11:0] FLAGS_RST = 12'h000;
   localparam logic [11:0] SLOT_ACLEAR_RST = 12'hfff;
   localparam logic FIFO_ACLEAR_RST = 1'h1;
   localparam logic [10:0] FIFO_THRESH_RST = 11'h000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   // bus answer latency in cycles after the request is first seen
   localparam int unsigned BUS_WAIT_CYCLES = 1;

   // per-slot strobes from the data path (same clock domain)
   typedef struct packed {
      logic [11:0] update;   // slot data registers being updated
      logic [11:0] lvl0_hit; // level 0 comparison result
      logic [11:0] lvl1_hit; // level 1 comparison result
      logic [11:0] rd;       // slot data registers being read
   } slot_evt_t;

   // fifo strobes and occupancy from the fifo logic
   typedef struct packed {
      logic wr;               // a fifo write this cycle
      logic rd;               // a fifo data read this cycle
      logic [10:0] byte_cnt;  // bytes held in the fifo
   } fifo_evt_t;
endpackage : slot_lvl_pkg

// *** core/slot_level_interrupt_status.sv ***
`timescale 1ns/100ps
`default_nettype none

module slot_level_interrupt_status
   import slot_lvl_pkg::*;
(
   input wire logic ref_clk_i,            // block clock, 100 MHz
   input wire logic rst_n_i,              // asynchronous reset, low
   // avalon-mm slave
   input wire logic [7:0] address_i,      // byte address
   input wire logic read_i,               // read request
   input wire logic write_i,              // write request
   input wire logic [3:0] byteenable_i,   // byte lanes of write
   input wire logic [31:0] writedata_i,   // write data
   output logic [31:0] readdata_o,        // read data, registered
   output logic waitrequest_o,            // stall until answer
   // data path strobes
   input wire slot_evt_t slot_evt_i,      // per-slot strobes
   input wire fifo_evt_t fifo_evt_i,      // fifo strobes and count
   // outputs
   output logic [10:0] fifo_thresh_value_o, // threshold to fifo logic
   output logic irq_o                     // level interrupt
);

   // ---------------------------------------------------------------
   // bus handshake
   // ---------------------------------------------------------------

   logic ack_r;            // high in the cycle the answer is given
   logic [31:0] rdata_r;   // captured read word
   logic req;              // any request present
   logic wr_go;            // write takes effect this edge
   logic rd_go;            // read is answered this edge
   logic [5:0] idx;        // register index from byte address
   logic [15:0] wr_data;   // write word masked to enabled lanes
   logic [15:0] rd_word;   // register word selected for read

   assign req = read_i | write_i;
   assign idx = address_i[7:2];
   // only the low two lanes carry register bits
   assign wr_data = writedata_i[15:0] &
      {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

   // one wait cycle, then release; the answer never takes longer
   // a request seen with ack low stalls one cycle; the next edge
   // both applies a write and hands back the word captured for a
   // read, so a master never sees more than one wait state
   assign waitrequest_o = req & ~ack_r;
   assign wr_go = write_i & ack_r;
   assign rd_go = read_i & ack_r;

   // ack toggles for exactly one cycle per request
   // a master that keeps its request up after the answer starts a
   // fresh transfer, so a write held too long lands twice
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_r <= 1'b0;
      end else begin
         // a held request gets a fresh ack every other cycle
         ack_r <= req & ~ack_r;
      end
   end

   // ---------------------------------------------------------------
   // flag registers
   // ---------------------------------------------------------------

   logic [11:0] lvl0_r;         // level 0 flags, slots a to l
   logic [11:0] lvl1_r;         // level 1 flags, slots a to l
   logic [11:0] ready_r;        // data ready flags, slots a to l
   logic fifo_thresh_flag_r;    // fifo threshold flag
   logic [11:0] slot_aclear_r;  // per-slot autoclear enables
   logic fifo_aclear_r;         // fifo threshold autoclear enable
   logic [10:0] thresh_r;       // fifo threshold value
   logic [15:0] mask_data_r;    // irq mask for ready word
   logic [15:0] mask_lvl0_r;    // irq mask for level 0 word
   logic [15:0] mask_lvl1_r;    // irq mask for level 1 word

   // write-one-clear strobes per word, valid only on accepted write
   // strobes are gated by the handshake edge so a stalled write
   // cannot clear a flag early
   logic [11:0] w1c_lvl0;
   logic [11:0] w1c_lvl1;
   logic [11:0] w1c_ready;
   logic w1c_fifo;

   // set terms from the data path
   // all strobes arrive on this clock, so no synchroniser is needed
   logic [11:0] set_lvl0;
   logic [11:0] set_lvl1;
   logic [11:0] set_ready;
   logic set_fifo;

   // autoclear terms
   // a read strobe without its enable bit leaves the flag standing
   logic [11:0] ac_ready;
   logic ac_fifo;

   // next values
   // each is a pure function of present flags and this cycle's strobes
   logic [11:0] lvl0_nxt;
   logic [11:0] lvl1_nxt;
   logic [11:0] ready_nxt;
   logic fifo_thresh_flag_nxt;

   // decode of w1c writes; a zero bit leaves the flag alone
   // reserved bits 14 to 12 of a written word are simply dropped
   always_comb begin
      w1c_lvl0 = '0;
      w1c_lvl1 = '0;
      w1c_ready = '0;
      w1c_fifo = 1'b0;
      if (wr_go) begin
         unique case (idx)
            IDX_LEVEL0_FLAGS: begin
               w1c_lvl0 = wr_data[11:0];
            end
            IDX_LEVEL1_FLAGS: begin
               w1c_lvl1 = wr_data[11:0];
            end
            IDX_DATA_FLAGS: begin
               w1c_ready = wr_data[11:0];
               w1c_fifo = wr_data[FIFO_THRESH_BIT];
            end
            default: begin
               // other indices carry no clear bits
               w1c_fifo = 1'b0;
            end
         endcase
      end
   end

   // comparison results count only with the update strobe
   assign set_lvl0 = slot_evt_i.update & slot_evt_i.lvl0_hit;
   assign set_lvl1 = slot_evt_i.update & slot_evt_i.lvl1_hit;
   assign set_ready = slot_evt_i.update;
   // strictly greater than the threshold
   assign set_fifo = fifo_evt_i.wr &
      (fifo_evt_i.byte_cnt > thresh_r);

   // reads clear ready flags only where autoclear is enabled
   assign ac_ready = slot_evt_i.rd & slot_aclear_r;
   assign ac_fifo = fifo_evt_i.rd & fifo_aclear_r;

   // set wins over any clear landing in the same cycle
   // losing the clear is harmless: software sees the flag again and
   // clears it once more, whereas a lost set would hide an event
   assign lvl0_nxt = set_lvl0 | (lvl0_r & ~w1c_lvl0);
   assign lvl1_nxt = set_lvl1 | (lvl1_r & ~w1c_lvl1);
   assign ready_nxt = set_ready |
      (ready_r & ~(w1c_ready | ac_ready));
   assign fifo_thresh_flag_nxt = set_fifo |
      (fifo_thresh_flag_r & ~(w1c_fifo | ac_fifo));

   // level flag banks
   // reset clears both banks so no stale level event survives
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lvl0_r <= FLAGS_RST;
         lvl1_r <= FLAGS_RST;
      end else begin
         lvl0_r <= lvl0_nxt;
         lvl1_r <= lvl1_nxt;
      end
   end

   // data ready and fifo threshold flags
   // kept apart from the level banks since these also autoclear
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_r <= FLAGS_RST;
         fifo_thresh_flag_r <= 1'b0;
      end else begin
         ready_r <= ready_nxt;
         fifo_thresh_flag_r <= fifo_thresh_flag_nxt;
      end
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------

   // autoclear enables; bits 14 to 12 are not stored
   // every enable comes out of reset set, so reads clear by default
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slot_aclear_r <= SLOT_ACLEAR_RST;
         fifo_aclear_r <= FIFO_ACLEAR_RST;
      end else if (wr_go && idx == IDX_ACLEAR_EN) begin
         // only enabled lanes update, so keep lane-wise merge
         if (byteenable_i[0]) begin
            slot_aclear_r[7:0] <= writedata_i[7:0];
         end
         if (byteenable_i[1]) begin
            slot_aclear_r[11:8] <= writedata_i[11:8];
            fifo_aclear_r <= writedata_i[FIFO_ACLEAR_BIT];
         end
      end
   end

   // fifo threshold value, compared against the byte count
   // the comparison is strict, so a threshold of zero fires on the
   // first byte written and the largest value never fires
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         thresh_r <= FIFO_THRESH_RST;
      end else if (wr_go && idx == IDX_FIFO_THRESH) begin
         if (byteenable_i[0]) begin
            thresh_r[7:0] <= writedata_i[7:0];
         end
         if (byteenable_i[1]) begin
            thresh_r[10:8] <= writedata_i[10:8];
         end
      end
   end

   // interrupt masks, same layout as the flag words
   // masks reset to zero so the line stays quiet until software opts in
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_data_r <= MASK_RST;
         mask_lvl0_r <= MASK_RST;
         mask_lvl1_r <= MASK_RST;
      end else if (wr_go) begin
         // unused mask bits are stored but gate nothing
         if (idx == IDX_MASK_DATA) begin
            mask_data_r <= (mask_data_r &
               ~{{8{byteenable_i[1]}}, {8{byteenable_i[0]}}}) | wr_data;
         end
         if (idx == IDX_MASK_LEVEL0) begin
            mask_lvl0_r <= (mask_lvl0_r &
               ~{{8{byteenable_i[1]}}, {8{byteenable_i[0]}}}) | wr_data;
         end
         if (idx == IDX_MASK_LEVEL1) begin
            mask_lvl1_r <= (mask_lvl1_r &
               ~{{8{byteenable_i[1]}}, {8{byteenable_i[0]}}}) | wr_data;
         end
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------

   // word views of the flag registers, reserved bits zero
   // bits 14 to 12 of the data and autoclear words are tied low
   logic [15:0] data_word;
   logic [15:0] lvl0_word;
   logic [15:0] lvl1_word;
   logic [15:0] aclear_word;

   assign data_word = {fifo_thresh_flag_r, 3'h0, ready_r};
   assign lvl0_word = {4'h0, lvl0_r};
   assign lvl1_word = {4'h0, lvl1_r};
   assign aclear_word = {fifo_aclear_r, 3'h0, slot_aclear_r};

   // register select; unmapped indices read zero
   // the select is purely combinational; the word is latched below
   always_comb begin
      unique case (idx)
         IDX_DATA_FLAGS: begin
            rd_word = data_word;
         end
         IDX_LEVEL0_FLAGS: begin
            rd_word = lvl0_word;
         end
         IDX_LEVEL1_FLAGS: begin
            rd_word = lvl1_word;
         end
         IDX_ACLEAR_EN: begin
            rd_word = aclear_word;
         end
         IDX_FIFO_THRESH: begin
            rd_word = {5'h00, thresh_r};
         end
         IDX_MASK_DATA: begin
            rd_word = mask_data_r;
         end
         IDX_MASK_LEVEL0: begin
            rd_word = mask_lvl0_r;
         end
         IDX_MASK_LEVEL1: begin
            rd_word = mask_lvl1_r;
         end
         default: begin
            // unmapped: answer with zero, never stall forever
            rd_word = 16'h0000;
         end
      endcase
   end

   // capture in the wait cycle so data stands when wait drops;
   // a status read has no side effect on the flags
   // autoclear comes from the data path read strobes instead, so a
   // register read of the flag word never loses an event
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (read_i && !ack_r) begin
         rdata_r <= {16'h0000, rd_word};
      end
   end

   assign readdata_o = rdata_r;

   // ---------------------------------------------------------------
   // interrupt output
   // ---------------------------------------------------------------

   logic irq_r;     // registered level interrupt
   logic irq_nxt;   // any unmasked flag set

   // registered to keep glitches off the pin; costs one cycle
   // so the line trails the flag by one clock after it is set
   assign irq_nxt = |(data_word & mask_data_r) |
      |(lvl0_word & mask_lvl0_r) |
      |(lvl1_word & mask_lvl1_r);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   assign irq_o = irq_r;
   assign fifo_thresh_value_o = thresh_r;

   // rd_go marks the read handshake edge; kept for clarity only
   logic unused_rd_go;
   assign unused_rd_go = rd_go;

endmodule : slot_level_interrupt_status

`default_nettype wire

// *** bench/slot_lvl_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
// port-level watch on the bus handshake, threshold and interrupt line
module slot_lvl_monitor
   import slot_lvl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [3:0] byteenable_i,
   input wire logic [31:0] writedata_i,
   input wire logic [31:0] readdata_o,
   input wire logic waitrequest_o,
   input wire slot_evt_t slot_evt_i,
   input wire fifo_evt_t fifo_evt_i,
   input wire logic [10:0] fifo_thresh_value_o,
   input wire logic irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // a write completing on the threshold register, any lanes on
   wire logic th_any = write_i && !waitrequest_o &&
      address_i[7:2] == IDX_FIFO_THRESH;
   // the same write with both low lanes on
   wire logic th_wr = th_any && byteenable_i[1:0] == 2'h3;
   chk_wait_first: assert property ((read_i || write_i) &&
      !$past(read_i || write_i) |-> waitrequest_o) else $error("no stall");
   chk_one_wait: assert property (waitrequest_o |=> !waitrequest_o)
      else $error("stall too long");
   chk_idle_free: assert property (!(read_i || write_i) |->
      !waitrequest_o) else $error("stall while idle");
   chk_rd_upper: assert property (readdata_o[31:16] == 16'h0000)
      else $error("upper read bits set");
   chk_rd_hold: assert property (!read_i |=> $stable(readdata_o))
      else $error("read data moved");
   chk_th_load: assert property (th_wr |=>
      fifo_thresh_value_o == $past(writedata_i[10:0]))
      else $error("threshold not loaded");
   chk_th_hold: assert property (!th_any |=>
      $stable(fifo_thresh_value_o)) else $error("threshold moved");
   chk_irq_cause: assert property ($rose(irq_o) |-> $past(write_i ||
      (|slot_evt_i.update) || fifo_evt_i.wr, 2)) else $error("irq no cause");
   chk_irq_drop: assert property ($fell(irq_o) |-> $past(write_i ||
      (|slot_evt_i.rd) || fifo_evt_i.rd, 2)) else $error("irq fell alone");
endmodule : slot_lvl_monitor

bind slot_level_interrupt_status slot_lvl_monitor i_mon (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .address_i(address_i),
   .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
   .writedata_i(writedata_i), .readdata_o(readdata_o),
   .waitrequest_o(waitrequest_o), .slot_evt_i(slot_evt_i),
   .fifo_evt_i(fifo_evt_i), .fifo_thresh_value_o(fifo_thresh_value_o),
   .irq_o(irq_o));
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
// random and corner traffic against the slot flag banks
module testbench;
   import slot_lvl_pkg::*;
   logic ref_clk_i, rst_n_i, read_i, write_i, waitrequest_o, irq_o;
   logic [7:0] address_i;
   logic [3:0] be; // byte lanes of the request
   logic [31:0] writedata_i, readdata_o, rd;
   logic [10:0] th_o, t; // threshold seen and programmed
   slot_evt_t slot_evt_i;
   fifo_evt_t fifo_evt_i;
   logic [11:0] e0, e1, er, u, h0, h1, a; // expected banks and draws
   logic ef; // expected fifo threshold flag
   int n_errors = 0;
   int n_checks = 0;
   // all lanes on unless a corner case narrows them
   slot_level_interrupt_status i_slot_level_interrupt_status (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .byteenable_i(be),
      .writedata_i(writedata_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .slot_evt_i(slot_evt_i),
      .fifo_evt_i(fifo_evt_i), .fifo_thresh_value_o(th_o), .irq_o(irq_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one avalon cycle; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] ix,
      input logic [15:0] d);
      @(posedge ref_clk_i);
      address_i <= {ix, 2'b00};
      read_i <= !w;
      write_i <= w;
      writedata_i <= {16'h0000, d};
      @(posedge ref_clk_i iff !waitrequest_o);
      rd = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [5:0] ix, input logic [15:0] exp);
      bus(1'b0, ix, 16'h0000);
      chk(rd, {16'h0000, exp});
   endtask : rchk
   // one-cycle strobes; returns at the edge that takes them
   task automatic evt(input logic [11:0] up, l0, l1, r);
      @(posedge ref_clk_i) slot_evt_i <= {up, l0, l1, r};
      @(posedge ref_clk_i) slot_evt_i <= '0;
   endtask : evt
   task automatic fev(input logic w, r, input logic [10:0] c);
      @(posedge ref_clk_i) fifo_evt_i <= {w, r, c};
      @(posedge ref_clk_i) fifo_evt_i <= {2'b00, c};
   endtask : fev
   // expected flag words
   function automatic logic [11:0] setf(input logic [11:0] o, up, hit);
      return o | (up & hit);
   endfunction : setf
   function automatic logic [15:0] dword();
      return {ef, 3'h0, er};
   endfunction : dword
   initial begin
      rst_n_i = 1'b0;
      {read_i, write_i, address_i, writedata_i} = '0;
      be = 4'hf;
      slot_evt_i = '0;
      fifo_evt_i = '0;
      {e0, e1, er, ef} = '0;
      void'($urandom(47));
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rchk(IDX_LEVEL0_FLAGS, 16'h0000);
      rchk(IDX_LEVEL1_FLAGS, 16'h0000);
      rchk(IDX_ACLEAR_EN, 16'h8fff);
      bus(1'b1, 6'h3f, 16'hffff);
      rchk(6'h3f, 16'h0000);
      for (int i = 0; i < 40; i++) begin
         // first pass hits every slot in both banks
         u = (i == 0) ? 12'hfff : 12'($urandom);
         h0 = (i == 0) ? 12'hfff : 12'($urandom);
         h1 = (i == 0) ? 12'hfff : 12'($urandom);
         a = 12'($urandom);
         evt(u, h0, h1, 12'h000);
         e0 = setf(e0, u, h0);
         e1 = setf(e1, u, h1);
         er = setf(er, u, 12'hfff);
         rchk(IDX_LEVEL0_FLAGS, {4'h0, e0});
         rchk(IDX_LEVEL1_FLAGS, {4'h0, e1});
         rchk(IDX_DATA_FLAGS, dword());
         bus(1'b1, IDX_LEVEL0_FLAGS, {4'hf, a});
         bus(1'b1, IDX_LEVEL1_FLAGS, {4'hf, ~a});
         bus(1'b1, IDX_DATA_FLAGS, {4'h0, a});
         e0 = e0 & ~a;
         e1 = e1 & a;
         er = er & ~a;
         rchk(IDX_LEVEL0_FLAGS, {4'h0, e0});
         rchk(IDX_LEVEL1_FLAGS, {4'h0, e1});
      end
      // slot autoclear with a random enable pattern, fifo one off
      a = 12'($urandom);
      bus(1'b1, IDX_ACLEAR_EN, {4'h7, a});
      rchk(IDX_ACLEAR_EN, {4'h0, a});
      evt(12'hfff, 12'h000, 12'h000, 12'h000);
      evt(12'h000, 12'h000, 12'h000, 12'hfff);
      er = 12'hfff & ~a;
      rchk(IDX_DATA_FLAGS, dword());
      // threshold compare is strict: equal count must not set
      t = {1'b0, 10'($urandom)};
      bus(1'b1, IDX_FIFO_THRESH, {5'h00, t});
      #1 chk({21'h0, th_o}, {21'h0, t});
      fev(1'b1, 1'b0, t);
      rchk(IDX_DATA_FLAGS, dword());
      fev(1'b1, 1'b0, t + 11'h1);
      ef = 1'b1;
      rchk(IDX_DATA_FLAGS, dword());
      fev(1'b0, 1'b1, t + 11'h1);
      rchk(IDX_DATA_FLAGS, dword());
      bus(1'b1, IDX_ACLEAR_EN, 16'h8000);
      fev(1'b0, 1'b1, t + 11'h1);
      ef = 1'b0;
      rchk(IDX_DATA_FLAGS, dword());
      fev(1'b1, 1'b0, t + 11'h1);
      bus(1'b1, IDX_DATA_FLAGS, 16'h8000);
      rchk(IDX_DATA_FLAGS, dword());
      // single low lane: threshold bits 10 to 8 keep their old value
      be <= 4'h1;
      bus(1'b1, IDX_FIFO_THRESH, 16'h07ff);
      be <= 4'hf;
      #1 chk({21'h0, th_o}, {21'h0, t[10:8], 8'hff});
      // interrupt: masked-out slot stays quiet, masked-in slot raises
      bus(1'b1, IDX_LEVEL0_FLAGS, 16'h0fff);
      bus(1'b1, IDX_MASK_LEVEL0, 16'h0008);
      evt(12'h010, 12'h010, 12'h000, 12'h000);
      repeat (2) @(posedge ref_clk_i);
      #1 chk({31'h0, irq_o}, 32'h0);
      evt(12'h008, 12'h008, 12'h000, 12'h000);
      repeat (2) @(posedge ref_clk_i);
      #1 chk({31'h0, irq_o}, 32'h1);
      bus(1'b1, IDX_LEVEL0_FLAGS, 16'h0008);
      @(posedge ref_clk_i);
      #1 chk({31'h0, irq_o}, 32'h0);
      // the other two mask words each raise the line on their own
      bus(1'b1, IDX_MASK_DATA, 16'h8000);
      fev(1'b1, 1'b0, 11'h7ff);
      repeat (2) @(posedge ref_clk_i);
      #1 chk({31'h0, irq_o}, 32'h1);
      bus(1'b1, IDX_DATA_FLAGS, 16'h8000);
      bus(1'b1, IDX_LEVEL1_FLAGS, 16'h0fff);
      bus(1'b1, IDX_MASK_LEVEL1, 16'h0001);
      @(posedge ref_clk_i);
      #1 chk({31'h0, irq_o}, 32'h0);
      evt(12'h001, 12'h000, 12'h001, 12'h000);
      repeat (2) @(posedge ref_clk_i);
      #1 chk({31'h0, irq_o}, 32'h1);
      // reset in mid-run: flags, settings and the line return to idle
      @(posedge ref_clk_i) rst_n_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      #1 chk({31'h0, irq_o}, 32'h0);
      chk({21'h0, th_o}, {21'h0, FIFO_THRESH_RST});
      rchk(IDX_LEVEL1_FLAGS, 16'h0000);
      rchk(IDX_DATA_FLAGS, 16'h0000);
      rchk(IDX_ACLEAR_EN, 16'h8fff);
      final_report();
   end
   // the run needs about 1200 cycles; cut a hang well beyond that
   initial begin
      #300000;
      n_errors++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
